/* rtl/tofst_regs.svh */
// offsets, field positions, reset values and timing counts of the
// turn-off timing and status register bank
// assumes one 125 MHz clock and a host command port decoded upstream
//
// What this block does
// - disable waits delay setting times 10 us
// - delay setting paged, read/write, resets to zero
// - ramp down lasts fall setting microseconds
// - fall setting paged, read/write, resets 500 us
// - new fall time used only after commit
// - status byte global, read-only, both outputs
// - bit 6 set while output ramps down or delivers no power
// - bits 5..1 ov, oc, vin uv, temp, cml
// - bit 0 other change, bit 7 zero
// - status word low byte equals status byte
// - word bits 15..12 vout, iout, input, mfr
// - word bit 11 set while power not good
// - vout status bits 7, 4, 3; rest zero
`ifndef TOFST_REGS_SVH
`define TOFST_REGS_SVH

// ************************************************************
// command codes
// ************************************************************
`define TOFST_CODE_DELAY 8'h64
`define TOFST_CODE_FALL  8'h65
`define TOFST_CODE_BYTE  8'h78
`define TOFST_CODE_WORD  8'h79
`define TOFST_CODE_VOUT  8'h7a

// ************************************************************
// reset values
// ************************************************************
`define TOFST_DELAY_RST 16'h0000
`define TOFST_FALL_RST  16'h01f4

// ************************************************************
// summary and detail bit positions
// ************************************************************
`define TOFST_SB_OFF    6
`define TOFST_SB_OV     5
`define TOFST_SB_OC     4
`define TOFST_SB_VINUV  3
`define TOFST_SB_TEMP   2
`define TOFST_SB_CML    1
`define TOFST_SB_OTHER  0
`define TOFST_SW_VOUT   15
`define TOFST_SW_IOUT   14
`define TOFST_SW_INPUT  13
`define TOFST_SW_MFR    12
`define TOFST_SW_PGN    11
`define TOFST_SV_OV     7
`define TOFST_SV_UV     4
`define TOFST_SV_MAX    3

// ************************************************************
// timing
// ************************************************************
`define TOFST_US_NS      1000
`define TOFST_CLK_NS     8
`define TOFST_CYC_PER_US (`TOFST_US_NS / `TOFST_CLK_NS)
`define TOFST_DELAY_LSB_US 10
`define TOFST_FALL_LSB_US  1

`endif

/* rtl/tofst_pkg.sv */
// types shared by the turn-off timing and status bank
// assumes the constants header is included by the files that use it
package tofst_pkg;

  // ************************************************************
  // host command, per-output fault events and global events
  // ************************************************************
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       page;
    logic [7:0] code;
    logic [15:0] wdata;
  } tofst_cmd_s;

  typedef struct packed {
    logic ov;
    logic uv;
    logic vmax;
    logic oc;
  } tofst_fault_s;

  typedef struct packed {
    logic vin_uv;
    logic in_flt;   // input voltage fault other than undervoltage
    logic temp;
    logic cml;
    logic mfr;
    logic other;
  } tofst_glob_s;

  typedef enum logic [1:0] {TOFST_ON, TOFST_WAIT, TOFST_FALL, TOFST_DOWN}
    tofst_seq_e;

endpackage

/* rtl/tofst_seq.sv */
// one output's turn-off sequencer: delay, then timed ramp-down
// assumes enable is synchronous and settings are stable while used
`include "tofst_regs.svh"
module tofst_seq
  import tofst_pkg::*;
#(
  parameter int CYC_PER_US = `TOFST_CYC_PER_US
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic [15:0] delay,
  input  wire logic [15:0] fall,
  output logic             off,
  output logic             ramp,
  output logic             pg
);

  typedef struct packed {
    tofst_seq_e  st;
    logic [15:0] pre;
    logic [19:0] us;
    logic        off;
    logic        ramp;
    logic        pg;
  } tofst_sq_s;

  tofst_sq_s   q;
  tofst_sq_s   d;
  logic        tick;
  logic [19:0] tgt;

  // every assertion below runs on clk and sleeps through reset
  default clocking @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  if (CYC_PER_US < 1 || CYC_PER_US > 65535)
  begin : g_chk
    $error("CYC_PER_US out of range");
  end

  // delay in microseconds; 16 bits times 10 fits in 20 bits
  assign tgt  = 20'(delay) * 20'(`TOFST_DELAY_LSB_US);
  assign tick = (q.pre == 16'(CYC_PER_US - 1));

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d = q;
    d.pre = (q.st == TOFST_WAIT || q.st == TOFST_FALL) && !tick ?
            q.pre + 16'h0001 : 16'h0000;
    case (q.st)
      TOFST_ON:
      begin
        d.us = 20'h00000;
        if (!en)
        begin
          // zero delay skips straight to the ramp, or straight to off if fall is also zero
          if (tgt != 20'h00000)
            d.st = TOFST_WAIT;
          else if (fall != 16'h0000)
            d.st = TOFST_FALL;
          else
            d.st = TOFST_DOWN;
          d.pre = 16'h0000;
        end
      end
      TOFST_WAIT:
      begin
        if (en)
          d.st = TOFST_ON;
        else if (q.us == tgt)
        begin
          d.st  = fall != 16'h0000 ? TOFST_FALL : TOFST_DOWN;
          d.us  = 20'h00000;
          d.pre = 16'h0000;
        end
        else if (tick)
          d.us = q.us + 20'h00001;
      end
      TOFST_FALL:
      begin
        // re-enable aborts the ramp rather than finishing it
        if (en)
          d.st = TOFST_ON;
        else if (q.us == 20'(fall))
          d.st = TOFST_DOWN;
        else if (tick)
          d.us = q.us + 20'h00001;
      end
      TOFST_DOWN:
      begin
        d.us = 20'h00000;
        if (en)
          d.st = TOFST_ON;
      end
      default: d.st = TOFST_DOWN;
    endcase
    d.off  = (d.st == TOFST_FALL || d.st == TOFST_DOWN);
    d.ramp = (d.st == TOFST_FALL);
    d.pg   = (d.st == TOFST_ON);
  end

  // ************************************************************
  // state register; output starts off
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q      <= '0;
      q.st   <= TOFST_DOWN;
      q.off  <= 1'b1;
    end
    else
      q <= d;
  end

  assign off  = q.off;
  assign ramp = q.ramp;
  assign pg   = q.pg;

  a_delay_exit: assert property (
    q.st == TOFST_WAIT && !en ##1 q.st != TOFST_WAIT && q.st != TOFST_ON
    |-> $past(q.us) == $past(tgt))
    else $error("delay left early or late");

  a_fall_exit: assert property (
    q.st == TOFST_FALL && !en ##1 q.st == TOFST_DOWN
    |-> $past(q.us) == 20'($past(fall)))
    else $error("ramp ended at wrong time");

  a_us_step: assert property (
    q.st == TOFST_FALL && !en && !tick && q.us != 20'(fall)
    |=> $stable(q.us))
    else $error("microsecond count moved without tick");

endmodule

/* rtl/tofst_bank.sv */
// turn-off timing and status register bank for two outputs
// assumes the host command port is already decoded from the serial
// link; commit and clear-faults come in as one-cycle strobes
`include "tofst_regs.svh"
module tofst_bank
  import tofst_pkg::*;
#(
  parameter int CYC_PER_US = `TOFST_CYC_PER_US
)(
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire tofst_cmd_s         CMD,
  input  wire logic               COMMIT,
  input  wire logic               CLEAR_FAULTS,
  input  wire logic [1:0]         OUT_EN,
  input  wire tofst_fault_s [1:0] FLT_EVT,
  input  wire tofst_glob_s        GLB_EVT,
  output logic                    RSP_VALID,
  output logic                    RSP_ERR,
  output logic [15:0]             RSP_DATA,
  output logic [1:0]              OUT_OFF,
  output logic [1:0]              OUT_RAMP,
  output logic [1:0]              OUT_PG
);

  typedef struct packed {
    logic [1:0][15:0]   delay;
    logic [1:0][15:0]   fall_pend;
    logic [1:0][15:0]   fall_act;
    tofst_fault_s [1:0] flt;
    tofst_glob_s        glb;
    logic               rsp_valid;
    logic               rsp_err;
    logic [15:0]        rsp_data;
  } tofst_bank_s;

  tofst_bank_s q;
  tofst_bank_s d;
  logic [7:0]  sbyte;
  logic [15:0] sword;
  logic [1:0][7:0] svout;
  logic        rd;
  logic        wr;

  // every check below runs on CLK and sleeps through reset
  default clocking @(posedge CLK);
  endclocking

  default disable iff (!RST_N);

  assign rd = CMD.valid && !CMD.write;
  assign wr = CMD.valid && CMD.write;

  // ************************************************************
  // per-output sequencers
  // ************************************************************
  for (genvar i = 0; i < 2; i++)
  begin : g_out
    tofst_seq #(.CYC_PER_US(CYC_PER_US)) u_seq (
      .clk   (CLK),
      .rst_n (RST_N),
      .en    (OUT_EN[i]),
      .delay (q.delay[i]),
      .fall  (q.fall_act[i]),
      .off   (OUT_OFF[i]),
      .ramp  (OUT_RAMP[i]),
      .pg    (OUT_PG[i])
    );
  end

  // ************************************************************
  // status views, built from sticky bits and live output state
  // ************************************************************
  always_comb
  begin
    sbyte = 8'h00;                                 // bit 7 zero
    sbyte[`TOFST_SB_OFF]   = |OUT_OFF;
    sbyte[`TOFST_SB_OV]    = q.flt[0].ov | q.flt[1].ov;
    sbyte[`TOFST_SB_OC]    = q.flt[0].oc | q.flt[1].oc;
    sbyte[`TOFST_SB_VINUV] = q.glb.vin_uv;
    sbyte[`TOFST_SB_TEMP]  = q.glb.temp;
    sbyte[`TOFST_SB_CML]   = q.glb.cml;
    sbyte[`TOFST_SB_OTHER] = q.glb.other;
    sword = {8'h00, sbyte};
    sword[`TOFST_SW_VOUT]  = |{q.flt[0].ov, q.flt[0].uv, q.flt[0].vmax,
                               q.flt[1].ov, q.flt[1].uv, q.flt[1].vmax};
    sword[`TOFST_SW_IOUT]  = q.flt[0].oc | q.flt[1].oc;
    sword[`TOFST_SW_INPUT] = q.glb.in_flt | q.glb.vin_uv;
    sword[`TOFST_SW_MFR]   = q.glb.mfr;
    sword[`TOFST_SW_PGN]   = ~&OUT_PG;
    for (int i = 0; i < 2; i++)
    begin
      svout[i] = 8'h00;
      svout[i][`TOFST_SV_OV]  = q.flt[i].ov;
      svout[i][`TOFST_SV_UV]  = q.flt[i].uv;
      svout[i][`TOFST_SV_MAX] = q.flt[i].vmax;
    end
  end

  // ************************************************************
  // next state: writes, commit, sticky faults, read answer
  // ************************************************************
  always_comb
  begin
    d = q;
    // commit copies the value pending before this cycle's write
    if (COMMIT)
      d.fall_act = q.fall_pend;
    d.rsp_valid = CMD.valid;
    d.rsp_err   = 1'b0;
    d.rsp_data  = 16'h0000;
    if (wr)
    begin
      case (CMD.code)
        `TOFST_CODE_DELAY: d.delay[CMD.page] = CMD.wdata;
        `TOFST_CODE_FALL:  d.fall_pend[CMD.page] = CMD.wdata;
        default:           d.rsp_err = 1'b1;   // status is read-only
      endcase
    end
    else if (rd)
    begin
      case (CMD.code)
        `TOFST_CODE_DELAY: d.rsp_data = q.delay[CMD.page];
        `TOFST_CODE_FALL:  d.rsp_data = q.fall_pend[CMD.page];
        `TOFST_CODE_BYTE:  d.rsp_data = {8'h00, sbyte};
        `TOFST_CODE_WORD:  d.rsp_data = sword;
        `TOFST_CODE_VOUT:  d.rsp_data = {8'h00, svout[CMD.page]};
        default:           d.rsp_err  = 1'b1;
      endcase
    end
    // a new event in the clear cycle survives it
    for (int i = 0; i < 2; i++)
      d.flt[i] = (CLEAR_FAULTS ? '0 : q.flt[i]) | FLT_EVT[i];
    d.glb = (CLEAR_FAULTS ? '0 : q.glb) | GLB_EVT;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      q           <= '0;
      q.delay     <= {2{`TOFST_DELAY_RST}};
      q.fall_pend <= {2{`TOFST_FALL_RST}};
      q.fall_act  <= {2{`TOFST_FALL_RST}};
    end
    else
      q <= d;
  end

  assign RSP_VALID = q.rsp_valid;
  assign RSP_ERR   = q.rsp_err;
  assign RSP_DATA  = q.rsp_data;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_commit;
    COMMIT ##1 1'b1;
  endsequence

  // first edge out of reset: settings hold their defaults
  a_reset_vals: assert property (
    $rose(RST_N) |-> q.delay == {2{`TOFST_DELAY_RST}} &&
                     q.fall_pend == {2{`TOFST_FALL_RST}} &&
                     q.fall_act == {2{`TOFST_FALL_RST}})
    else $error("wrong reset settings");

  a_fall_commit: assert property (
    s_commit |-> q.fall_act == $past(q.fall_pend))
    else $error("commit did not load fall time");

  a_fall_hold: assert property (
    !COMMIT |=> $stable(q.fall_act))
    else $error("fall time changed without commit");

  a_word_low: assert property (
    rd && CMD.code == `TOFST_CODE_WORD
    |=> RSP_VALID && RSP_DATA[7:0] == $past(sbyte))
    else $error("word low byte differs from byte");

  a_byte_top: assert property (
    rd && CMD.code == `TOFST_CODE_BYTE |=> RSP_DATA[15:7] == 9'h000)
    else $error("status byte bit 7 not zero");

  a_off_bit: assert property (
    sbyte[`TOFST_SB_OFF] == (OUT_OFF != 2'b00))
    else $error("off bit wrong");

  a_pg_bit: assert property (
    sword[`TOFST_SW_PGN] == (OUT_PG != 2'b11))
    else $error("power-good bit wrong");

  a_sticky_flt: assert property (
    FLT_EVT[0].ov ##1 !CLEAR_FAULTS[*2] |-> sbyte[`TOFST_SB_OV])
    else $error("overvoltage bit not sticky");

  a_vout_map: assert property (
    FLT_EVT[1].uv |=> svout[1][`TOFST_SV_UV] && sword[`TOFST_SW_VOUT]
                      && svout[1][2:0] == 3'h0)
    else $error("vout status layout wrong");

  a_ro_write: assert property (
    wr && CMD.code == `TOFST_CODE_BYTE |=> RSP_ERR)
    else $error("write to status not refused");

  a_oc_bits: assert property (
    FLT_EVT[1].oc |=> sbyte[`TOFST_SB_OC] && sword[`TOFST_SW_IOUT])
    else $error("overcurrent summary missing");

endmodule

/* test/tofst_host.sv */
// host model driving the command port, commit and clear strobes
// assumes one clock; the bench calls its tasks once reset is released
module tofst_host
  import tofst_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_err,
  input  wire logic [15:0] rsp_data,
  output tofst_cmd_s       cmd,
  output logic             commit,
  output logic             clear_faults
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************
  // strobes
  // ************
  // idle low so that nothing is taken while reset is held
  initial
  begin
    cmd = '0;
    commit = 1'b0;
    clear_faults = 1'b0;
  end

  // one command pulse, then a bounded look for the one-cycle answer
  task automatic access(input logic wr, input logic pg,
    input logic [7:0] cd, input logic [15:0] wd,
    output logic ok, output logic err, output logic [15:0] rd);
    ok = 1'b0;
    err = 1'b0;
    rd = '0;
    @(posedge clk);
    cmd <= '{valid: 1'b1, write: wr, page: pg, code: cd, wdata: wd};
    @(posedge clk);
    cmd.valid <= 1'b0;
    repeat (3)
    begin
      #1;
      if (!ok && rsp_valid === 1'b1)
      begin
        ok = 1'b1;
        err = rsp_err;
        rd = rsp_data;
      end
      @(posedge clk);
    end
  endtask

  // commit pending settings; owed again after any fall time write
  task automatic send_commit();
    @(posedge clk);
    commit <= 1'b1;
    @(posedge clk);
    commit <= 1'b0;
  endtask

  // clear every sticky fault bit in one pulse
  task automatic send_clear();
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
  endtask
endmodule

/* test/tofst_bank_tb_top.sv */
// self-checking bench for the turn-off timing and status bank
// assumes the host model owns the command port; the bench drives
// enables and fault events by non-blocking assignment at the edge
`include "tofst_regs.svh"
module tofst_bank_tb_top
  import tofst_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  // short microsecond keeps the 500 us default ramp brief
  localparam int CPU = 2;
  localparam logic [7:0] C_DLY = `TOFST_CODE_DELAY;
  localparam logic [7:0] C_FALL = `TOFST_CODE_FALL;
  localparam logic [7:0] C_BYTE = `TOFST_CODE_BYTE;
  localparam logic [7:0] C_WORD = `TOFST_CODE_WORD;
  localparam logic [7:0] C_VOUT = `TOFST_CODE_VOUT;
  // one event source each: {output 1, output 0, global} events
  localparam logic [13:0] EV [14] = '{14'h0200, 14'h0100, 14'h0080,
    14'h0040, 14'h0020, 14'h0010, 14'h0008, 14'h0004, 14'h0002,
    14'h0001, 14'h2000, 14'h1000, 14'h0800, 14'h0400};
  localparam logic [15:0] WD [14] = '{16'h8020, 16'h8000, 16'h8000,
    16'h4010, 16'h2008, 16'h2000, 16'h0004, 16'h0002, 16'h1000,
    16'h0001, 16'h8020, 16'h8000, 16'h8000, 16'h4010};
  localparam logic [7:0] VO [14] = '{8'h80, 8'h10, 8'h08, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h10, 8'h08, 8'h00};

  logic               clk;
  logic               rst_n;
  tofst_cmd_s         cmd_w;
  logic               commit_w;
  logic               clear_w;
  logic [1:0]         out_en;
  tofst_fault_s [1:0] flt_evt;
  tofst_glob_s        glb_evt;
  logic               rsp_valid;
  logic               rsp_err;
  logic [15:0]        rsp_data;
  logic [1:0]         out_off;
  logic [1:0]         out_ramp;
  logic [1:0]         out_pg;
  int                 cyc;
  int                 t0;
  int                 bad_count;
  int                 checks_done;

  // ************
  // design, host model, clock
  // ************
  tofst_bank #(.CYC_PER_US(CPU)) tofst_bank_inst (
    .CLK          (clk),
    .RST_N        (rst_n),
    .CMD          (cmd_w),
    .COMMIT       (commit_w),
    .CLEAR_FAULTS (clear_w),
    .OUT_EN       (out_en),
    .FLT_EVT      (flt_evt),
    .GLB_EVT      (glb_evt),
    .RSP_VALID    (rsp_valid),
    .RSP_ERR      (rsp_err),
    .RSP_DATA     (rsp_data),
    .OUT_OFF      (out_off),
    .OUT_RAMP     (out_ramp),
    .OUT_PG       (out_pg)
  );

  tofst_host tofst_host_inst (
    .clk          (clk),
    .rsp_valid    (rsp_valid),
    .rsp_err      (rsp_err),
    .rsp_data     (rsp_data),
    .cmd          (cmd_w),
    .commit       (commit_w),
    .clear_faults (clear_w)
  );

  // free cycle count gives timings independent of the host tasks
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ************
  // checks and verdict
  // ************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    checks_done++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("mismatch at %0t got %h want %h..%h", $time, n, lo, hi);
    end
  endtask

  // one command; a missing answer ends the run
  task automatic xfer(input logic wr, input logic pg, input logic [7:0] cd,
    input logic [15:0] wd, input logic ee, input logic [15:0] ed);
    logic ok;
    logic err;
    logic [15:0] rd;
    tofst_host_inst.access(wr, pg, cd, wd, ok, err, rd);
    if (ok !== 1'b1)
    begin
      bad_count++;
      give_verdict();
    end
    else
    begin
      chk({15'h0000, err}, {15'h0000, ee});
      chk(rd, ed);
    end
  endtask

  // bounded wait for one output flag to reach a level
  task automatic wait_lvl(input int sel, input int o, input logic lvl);
    logic s;
    for (int n = 0; n < 1100; n++)
    begin
      @(posedge clk);
      #1;
      s = sel == 0 ? out_off[o] : sel == 1 ? out_ramp[o] : out_pg[o];
      if (s === lvl)
        return;
    end
    bad_count++;
    give_verdict();
  endtask

  // ************
  // main sequence
  // ************
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    out_en = 2'b00;
    flt_evt = '0;
    glb_evt = '0;
    cyc = 0;
    bad_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({14'h0000, out_off}, 16'h0003);
    for (int p = 0; p < 2; p++)
    begin
      xfer(1'b0, p[0], C_DLY, 16'h0000, 1'b0, `TOFST_DELAY_RST);
      xfer(1'b0, p[0], C_FALL, 16'h0000, 1'b0, `TOFST_FALL_RST);
    end
    xfer(1'b0, 1'b0, C_WORD, 16'h0000, 1'b0, 16'h0840);
    xfer(1'b0, 1'b1, C_BYTE, 16'h0000, 1'b0, 16'h0040);
    xfer(1'b1, 1'b0, C_BYTE, 16'h00ff, 1'b1, 16'h0000);
    xfer(1'b1, 1'b0, C_WORD, 16'hffff, 1'b1, 16'h0000);
    xfer(1'b1, 1'b1, C_VOUT, 16'h00ff, 1'b1, 16'h0000);
    xfer(1'b0, 1'b0, 8'h66, 16'h0000, 1'b1, 16'h0000);
    // both outputs on, then each event source alone and cleared
    @(posedge clk);
    out_en <= 2'b11;
    repeat (3) @(posedge clk);
    xfer(1'b0, 1'b0, C_WORD, 16'h0000, 1'b0, 16'h0000);
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clk);
      {flt_evt, glb_evt} <= EV[i];
      @(posedge clk);
      {flt_evt, glb_evt} <= 14'h0000;
      repeat (4) @(posedge clk);
      xfer(1'b0, 1'b0, C_WORD, 16'h0000, 1'b0, WD[i]);
      xfer(1'b0, 1'b0, C_BYTE, 16'h0, 1'b0, WD[i] & 16'h00ff);
      xfer(1'b0, i >= 10, C_VOUT, 16'h0, 1'b0, {8'h00, VO[i]});
      tofst_host_inst.send_clear();
      xfer(1'b0, 1'b0, C_WORD, 16'h0000, 1'b0, 16'h0000);
    end
    // output 0 gets a 10 us delay and a committed 4 us ramp
    xfer(1'b1, 1'b0, C_DLY, 16'h0001, 1'b0, 16'h0000);
    xfer(1'b0, 1'b0, C_DLY, 16'h0000, 1'b0, 16'h0001);
    xfer(1'b1, 1'b0, C_FALL, 16'h0004, 1'b0, 16'h0000);
    tofst_host_inst.send_commit();
    xfer(1'b1, 1'b1, C_FALL, 16'h0004, 1'b0, 16'h0000);
    xfer(1'b0, 1'b1, C_FALL, 16'h0000, 1'b0, 16'h0004);
    @(posedge clk);
    out_en[0] <= 1'b0;
    #1;
    t0 = cyc;
    wait_lvl(2, 0, 1'b0);
    chk_rng(cyc - t0, 1, 2);
    xfer(1'b0, 1'b0, C_WORD, 16'h0000, 1'b0, 16'h0800);
    wait_lvl(0, 0, 1'b1);
    chk_rng(cyc - t0, 10 * CPU, 10 * CPU + 4);
    t0 = cyc;
    wait_lvl(1, 0, 1'b0);
    chk_rng(cyc - t0, 4 * CPU, 4 * CPU + 3);
    xfer(1'b0, 1'b0, C_WORD, 16'h0000, 1'b0, 16'h0840);
    // output 0 re-enabled inside its delay never starts the ramp
    @(posedge clk);
    out_en[0] <= 1'b1;
    wait_lvl(2, 0, 1'b1);
    @(posedge clk);
    out_en[0] <= 1'b0;
    wait_lvl(2, 0, 1'b0);
    @(posedge clk);
    out_en[0] <= 1'b1;
    #1;
    t0 = cyc;
    wait_lvl(2, 0, 1'b1);
    chk_rng(cyc - t0, 1, 2);
    chk({15'h0000, out_off[0]}, 16'h0000);
    // output 1: no delay, uncommitted fall keeps the 500 us ramp
    @(posedge clk);
    out_en[1] <= 1'b0;
    #1;
    t0 = cyc;
    wait_lvl(0, 1, 1'b1);
    chk_rng(cyc - t0, 1, 3);
    t0 = cyc;
    wait_lvl(1, 1, 1'b0);
    chk_rng(cyc - t0, 500 * CPU, 500 * CPU + 3);
    tofst_host_inst.send_commit();
    @(posedge clk);
    out_en[1] <= 1'b1;
    wait_lvl(2, 1, 1'b1);
    @(posedge clk);
    out_en[1] <= 1'b0;
    wait_lvl(0, 1, 1'b1);
    t0 = cyc;
    wait_lvl(1, 1, 1'b0);
    chk_rng(cyc - t0, 4 * CPU, 4 * CPU + 3);
    give_verdict();
  end
endmodule
